// File: rtl/ashtmr_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef ASHTMR_MAP_SVH
`define ASHTMR_MAP_SVH

// ==========================================
// register offsets
`define ASHTMR_FIRST_STATUS_ADDR   8'h41
`define ASHTMR_SECOND_STATUS_ADDR  8'h42
`define ASHTMR_FIRST_MASK_ADDR     8'h74
`define ASHTMR_SECOND_MASK_ADDR    8'h75
`define ASHTMR_THIRD_CFG_ADDR      8'h78
`define ASHTMR_HOT_TIMER_ADDR      8'h79
`define ASHTMR_HOT_LIMIT_ADDR      8'h7A
`define ASHTMR_FOURTH_CFG_ADDR     8'h7D

// ==========================================
// field positions
`define ASHTMR_CFG3_ALERT_EN       0
`define ASHTMR_CFG3_HOT_EN         1
`define ASHTMR_CFG3_FULL_SPEED     2
`define ASHTMR_MASK1_SECOND_ALL    7

// ==========================================
// reset values
`define ASHTMR_MASK_RESET          8'h00
`define ASHTMR_CFG3_RESET          8'h00
`define ASHTMR_CFG4_RESET          8'h00
`define ASHTMR_LIMIT_RESET         8'h00

// ==========================================
// timing: timer resolution in microseconds and clock in MHz
`define ASHTMR_HOT_LSB_US          22760
`define ASHTMR_CLK_MHZ             100
`define ASHTMR_HOT_LSB_CYCLES      (`ASHTMR_HOT_LSB_US * `ASHTMR_CLK_MHZ)

`endif

// File: rtl/ashtmr_pkg.sv
// types shared by the alert status and hot timer block
package ashtmr_pkg;

	// ==========================================
	// role of the multi-function pin
	typedef enum logic [1:0] {
		ASHTMR_ROLE_TACH  = 2'h0,
		ASHTMR_ROLE_HOT   = 2'h1,
		ASHTMR_ROLE_ALERT = 2'h2,
		ASHTMR_ROLE_GPIO  = 2'h3
	} ashtmr_role_type;

	// ==========================================
	// out-of-limit conditions from the measuring logic
	typedef struct packed {
		logic       remote_two_temp_flag;  // remote 2 temperature
		logic       local_temp_flag;       // local temperature
		logic       remote_one_temp_flag;  // remote 1 temperature
		logic       supply_rail_flag;      // supply rail
		logic       cpu_core_rail;         // core rail
		logic       diode_two_fault;       // diode 2 open or short
		logic       diode_one_fault;       // diode 1 open or short
		logic       fourth_fan_slow;       // fan 4 below minimum
		logic       third_fan_slow;        // fan 3 below minimum
		logic       second_fan_slow;       // fan 2 below minimum
		logic       first_fan_slow;        // fan 1 below minimum
		logic       overtemp_limit_flag;   // hot temperature limit
	} ashtmr_cond_type;

	// ==========================================
	// hot timer state
	typedef struct packed {
		logic [21:0] pre;    // prescaler toward one resolution step
		logic [7:0]  units;  // whole resolution steps accumulated
		logic        seen;   // an assertion has been seen
	} ashtmr_tmr_state_type;

	// ==========================================
	// top-level state
	typedef struct packed {
		logic [7:0] st1;        // first status, bit 7 derived
		logic [7:0] st2;        // second status
		logic [7:0] mask1;      // first alert mask
		logic [7:0] mask2;      // second alert mask
		logic [7:0] cfg3;       // third configuration
		logic [7:0] cfg4;       // fourth configuration
		logic [7:0] limit;      // hot timer limit
		logic [7:0] rdata;      // read data
		logic       alert5_n;   // pin 5 alert, active low
		logic       mf_out;     // multi-function pin level
		logic       mf_oe_n;    // multi-function pin enable, low drives
		logic [2:0] full_speed; // per-fan full speed override
	} ashtmr_state_type;

endpackage

// File: rtl/ashtmr_timer.sv
// hot input assertion timer with saturating count and limit compare
`timescale 1ns/100ps

`include "ashtmr_map.svh"

module ashtmr_timer #(
	parameter int TICK_CYCLES = `ASHTMR_HOT_LSB_CYCLES
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// hot input and control
	input  wire logic       asserted_in,  // hot function active and pin low
	input  wire logic       rd_clear_in,  // timer register read pulse
	input  wire logic [7:0] limit_in,     // programmed timer limit
	// results
	output logic [7:0]      value_out,    // timer register contents
	output logic            exceeded_out  // value above the limit
);

	// ==========================================
	// state
	ashtmr_pkg::ashtmr_tmr_state_type s_ff;
	ashtmr_pkg::ashtmr_tmr_state_type nxt_s;

	// visible count: bit 0 on first assertion, whole steps from two on
	function automatic logic [7:0] shown(input logic [7:0] u, input logic v);
		shown = (u < 8'h02) ? {7'h00, v} : u;
	endfunction

	// ==========================================
	// next state
	always_comb begin
		nxt_s = s_ff;
		if (rd_clear_in) begin
			// cleared by read; restarts from one if still asserted
			nxt_s.units = 8'h00;
			nxt_s.pre   = 22'h00_0000;
			nxt_s.seen  = asserted_in;
		end else if (asserted_in) begin
			// accumulate only while asserted, pause otherwise
			nxt_s.seen = 1'b1;
			if (s_ff.units != 8'hFF) begin
				// hold at full scale
				if (s_ff.pre == 22'(TICK_CYCLES - 1)) begin
					nxt_s.pre   = 22'h00_0000;
					nxt_s.units = s_ff.units + 8'h01;
				end else begin
					nxt_s.pre = s_ff.pre + 22'h00_0001;
				end
			end
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================
	// results
	assign value_out    = shown(s_ff.units, s_ff.seen);
	assign exceeded_out = shown(s_ff.units, s_ff.seen) > limit_in;

endmodule

// File: rtl/ashtmr_top.sv
// alert status, masking, pin role and hot timer block
`timescale 1ns/100ps

`include "ashtmr_map.svh"

// Contract
// - diode faults set second status bits 7, 6
// - bit 5: fan 4 slow or timer exceeded
// - bits 4..2 flag fans 3..1 slow
// - bit 1 flags hot temperature limit exceeded
// - sticky bits; read clears only absent conditions
// - alert low while unmasked fault or unread
// - masks gate alert only, not status
// - first mask bit layout, bit 7 all second
// - second mask bit layout per source
// - second mask bit 5 masks timer events
// - alert off at reset; cfg3 bit 0 enables pin 5
// - cfg4 bits 1:0 select pin role
// - hot role needs cfg3 bit 1 too
// - override bit forces fans full while hot
// - override only acts on running fans
// - timer accumulates while hot input asserted
// - timer clears on read, saturates at full
// - bit 0 on first assertion, then steps
// - read during assertion restarts count from one
// - bit 5 clearable after timer read
// - timer above limit sets bit 5, alerts
// - limit zero flags first assertion
// - first status bit 7 summarises second
// - timer limit resets to zero
// - first status temperature and rail bit layout
module ashtmr_top #(
	parameter int HOT_TICK_CYCLES = `ASHTMR_HOT_LSB_CYCLES  // one timer step
) (
	// clock and reset
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	// register port from the serial bus engine
	input  wire logic [7:0]              reg_addr_in,
	input  wire logic [7:0]              reg_wdata_in,
	input  wire logic                    reg_wr_in,
	input  wire logic                    reg_rd_in,
	output logic [7:0]                   reg_rdata_out,
	// out-of-limit conditions
	input  wire ashtmr_pkg::ashtmr_cond_type cond_in,
	// fan state from the drive logic
	input  wire logic [2:0]              fans_running_in,
	output logic [2:0]                   full_speed_override_out,
	// pin 5 alert
	output logic                         alert_pin5_n_out,
	// multi-function pin
	input  wire logic                    mf_pin_in,
	output logic                         mf_pin_out,
	output logic                         mf_pin_oe_n_out,
	// general-purpose drive for the multi-function pin
	input  wire logic                    gpio_level_in,
	input  wire logic                    gpio_drive_in
);

	// ==========================================
	// declarations
	ashtmr_pkg::ashtmr_state_type s_ff;         // all top-level state, timer state kept in u_timer
	ashtmr_pkg::ashtmr_state_type nxt_s;        // next state
	ashtmr_pkg::ashtmr_role_type  role;         // pin role
	logic                         hot_on;       // hot function active
	logic                         hot_low;      // hot input asserted
	logic                         rd_st1;       // first status read
	logic                         rd_st2;       // second status read
	logic                         rd_tmr;       // timer read
	logic [7:0]                   tmr_value;    // timer contents
	logic                         tmr_over;     // timer above limit
	logic [7:0]                   cond1;        // first status conditions
	logic [7:0]                   cond2;        // second status conditions
	logic [7:0]                   pend1;        // unmasked first pending
	logic [7:0]                   pend2;        // unmasked second pending
	logic                         alert;        // any unmasked source

	// sticky status: set wins over a read, read clears absent bits only
	function automatic logic [7:0] sticky(
		input logic [7:0] cur,
		input logic [7:0] cond,
		input logic       rd
	);
		sticky = (rd ? (cur & cond) : cur) | cond;
	endfunction

	// ==========================================
	// pin role and hot input
	// role field comes straight from the fourth configuration
	assign role    = ashtmr_pkg::ashtmr_role_type'(s_ff.cfg4[1:0]);
	// hot needs its role and the enable bit
	assign hot_on  = (role == ashtmr_pkg::ASHTMR_ROLE_HOT) &
	                 s_ff.cfg3[`ASHTMR_CFG3_HOT_EN];
	// pin is active low
	assign hot_low = hot_on & ~mf_pin_in;

	// ==========================================
	// read strobes
	assign rd_st1 = reg_rd_in & (reg_addr_in == `ASHTMR_FIRST_STATUS_ADDR);
	assign rd_st2 = reg_rd_in & (reg_addr_in == `ASHTMR_SECOND_STATUS_ADDR);
	assign rd_tmr = reg_rd_in & (reg_addr_in == `ASHTMR_HOT_TIMER_ADDR);

	// ==========================================
	// hot timer
	ashtmr_timer #(
		.TICK_CYCLES (HOT_TICK_CYCLES)
	) u_timer (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.asserted_in  (hot_low),
		.rd_clear_in  (rd_tmr),
		.limit_in     (s_ff.limit),
		.value_out    (tmr_value),
		.exceeded_out (tmr_over)
	);

	// ==========================================
	// condition vectors in status bit order
	always_comb begin
		cond1    = 8'h00;
		// temperatures in bits 6..4, rails in bits 2 and 1
		cond1[6] = cond_in.remote_two_temp_flag;
		cond1[5] = cond_in.local_temp_flag;
		cond1[4] = cond_in.remote_one_temp_flag;
		cond1[2] = cond_in.supply_rail_flag;
		cond1[1] = cond_in.cpu_core_rail;
		cond2    = 8'h00;
		// diode faults
		cond2[7] = cond_in.diode_two_fault;
		cond2[6] = cond_in.diode_one_fault;
		// fan 4 or, in hot role, timer beyond limit
		cond2[5] = hot_on ? tmr_over : cond_in.fourth_fan_slow;
		// fans 3..1
		cond2[4] = cond_in.third_fan_slow;
		cond2[3] = cond_in.second_fan_slow;
		cond2[2] = cond_in.first_fan_slow;
		// hot temperature limit
		cond2[1] = cond_in.overtemp_limit_flag;
	end

	// ==========================================
	// next state
	always_comb begin
		nxt_s = s_ff;

		// status capture, unaffected by masks
		nxt_s.st1 = sticky(s_ff.st1, cond1, rd_st1);
		// second status read lets bit 5 clear once its condition is gone
		nxt_s.st2 = sticky(s_ff.st2, cond2, rd_st2);

		// masking of first status sources
		pend1    = 8'h00;
		pend1[6] = nxt_s.st1[6] & ~s_ff.mask1[6];
		pend1[5] = nxt_s.st1[5] & ~s_ff.mask1[5];
		pend1[4] = nxt_s.st1[4] & ~s_ff.mask1[4];
		pend1[2] = nxt_s.st1[2] & ~s_ff.mask1[2];
		// core rail status bit 1 is masked by bit 0
		pend1[1] = nxt_s.st1[1] & ~s_ff.mask1[0];

		// masking of second status sources, bit 5 also for timer events
		pend2 = nxt_s.st2 & ~s_ff.mask2 & 8'hFE;

		// one line for everything unmasked, bit 7 covers all second sources
		alert = (|pend1) |
		        ((|pend2) & ~s_ff.mask1[`ASHTMR_MASK1_SECOND_ALL]);

		// pin 5 alert only when enabled
		nxt_s.alert5_n = ~(alert & s_ff.cfg3[`ASHTMR_CFG3_ALERT_EN]);

		// multi-function pin drive by role
		unique case (role)
			ashtmr_pkg::ASHTMR_ROLE_ALERT: begin
				// open drain, pulls low on alert
				nxt_s.mf_out  = 1'b0;
				nxt_s.mf_oe_n = ~alert;
			end
			ashtmr_pkg::ASHTMR_ROLE_GPIO: begin
				// driven from the general-purpose inputs
				nxt_s.mf_out  = gpio_level_in;
				nxt_s.mf_oe_n = ~gpio_drive_in;
			end
			ashtmr_pkg::ASHTMR_ROLE_TACH,
			ashtmr_pkg::ASHTMR_ROLE_HOT: begin
				// input roles, pin released
				nxt_s.mf_out  = 1'b1;
				nxt_s.mf_oe_n = 1'b1;
			end
		endcase

		// full speed while hot is low, only for fans already turning
		nxt_s.full_speed = fans_running_in &
		                   {3{hot_low & s_ff.cfg3[`ASHTMR_CFG3_FULL_SPEED]}};

		// register writes
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				`ASHTMR_FIRST_MASK_ADDR: begin
					nxt_s.mask1 = reg_wdata_in;
				end
				`ASHTMR_SECOND_MASK_ADDR: begin
					nxt_s.mask2 = reg_wdata_in;
				end
				`ASHTMR_THIRD_CFG_ADDR: begin
					nxt_s.cfg3 = reg_wdata_in;
				end
				`ASHTMR_HOT_LIMIT_ADDR: begin
					nxt_s.limit = reg_wdata_in;
				end
				`ASHTMR_FOURTH_CFG_ADDR: begin
					nxt_s.cfg4 = reg_wdata_in;
				end
				default: begin
					// read-only or unmapped, ignored
				end
			endcase
		end

		// register reads, data shown before any clearing
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`ASHTMR_FIRST_STATUS_ADDR: begin
					// bit 7 summarises the second status
					nxt_s.rdata = {|s_ff.st2, s_ff.st1[6:0]};
				end
				`ASHTMR_SECOND_STATUS_ADDR: begin
					nxt_s.rdata = s_ff.st2;
				end
				`ASHTMR_FIRST_MASK_ADDR: begin
					nxt_s.rdata = s_ff.mask1;
				end
				`ASHTMR_SECOND_MASK_ADDR: begin
					nxt_s.rdata = s_ff.mask2;
				end
				`ASHTMR_THIRD_CFG_ADDR: begin
					nxt_s.rdata = s_ff.cfg3;
				end
				`ASHTMR_HOT_TIMER_ADDR: begin
					nxt_s.rdata = tmr_value;
				end
				`ASHTMR_HOT_LIMIT_ADDR: begin
					nxt_s.rdata = s_ff.limit;
				end
				`ASHTMR_FOURTH_CFG_ADDR: begin
					nxt_s.rdata = s_ff.cfg4;
				end
				default: begin
					// unmapped reads as zero
					nxt_s.rdata = 8'h00;
				end
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_ff            <= '0;
			s_ff.mask1      <= `ASHTMR_MASK_RESET;
			s_ff.mask2      <= `ASHTMR_MASK_RESET;
			s_ff.cfg3       <= `ASHTMR_CFG3_RESET;
			s_ff.cfg4       <= `ASHTMR_CFG4_RESET;
			s_ff.limit      <= `ASHTMR_LIMIT_RESET;
			s_ff.alert5_n   <= 1'b1;
			s_ff.mf_out     <= 1'b1;
			s_ff.mf_oe_n    <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================
	// outputs straight from flops
	assign reg_rdata_out           = s_ff.rdata;
	assign full_speed_override_out = s_ff.full_speed;
	assign alert_pin5_n_out        = s_ff.alert5_n;
	assign mf_pin_out              = s_ff.mf_out;
	assign mf_pin_oe_n_out         = s_ff.mf_oe_n;

endmodule

// File: dv/ashtmr_assertions.sv
// port assertions for the alert status and hot timer block
`timescale 1ns/100ps

module ashtmr_assertions (
	// clock and reset
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// fans and pins
	input wire logic [2:0] fans_running_in,
	input wire logic [2:0] full_speed_override_out,
	input wire logic       alert_pin5_n_out,
	input wire logic       mf_pin_in,
	input wire logic       mf_pin_out,
	input wire logic       mf_pin_oe_n_out,
	input wire logic       gpio_level_in,
	input wire logic       gpio_drive_in
);
	// ==========================================
	// helpers
	logic mapped;  // address hits a register
	assign mapped = reg_addr_in inside {8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h79, 8'h7a, 8'h7d};

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// timer read while the hot pin is idle
	sequence s_tmr_rd;
		reg_rd_in && reg_addr_in == 8'h79 && mf_pin_in;
	endsequence
	// quiet cycle, pin idle
	sequence s_idle_high;
		!reg_rd_in && mf_pin_in;
	endsequence

	// ==========================================
	// assertions
	a_unmapped_reads_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	a_override_cause: assert property (full_speed_override_out != 3'h0 |->
		(full_speed_override_out & ~$past(fans_running_in)) == 3'h0 && !$past(mf_pin_in))
		else $error("override without running fan or hot pin");
	a_gpio_drive_high: assert property (!mf_pin_oe_n_out && mf_pin_out |->
		$past(gpio_drive_in) && $past(gpio_level_in))
		else $error("pin driven high outside gpio");
	a_reset_quiet: assert property ($rose(rst_n_in) |->
		alert_pin5_n_out && mf_pin_oe_n_out && full_speed_override_out == 3'h0)
		else $error("outputs active after reset");
	a_timer_read_clears: assert property (s_tmr_rd ##1 s_idle_high ##1 s_tmr_rd |=>
		reg_rdata_out == 8'h00)
		else $error("timer not cleared by read");
	a_first_spare_zero: assert property (reg_rd_in && reg_addr_in == 8'h41 |=>
		reg_rdata_out[3] == 1'b0 && reg_rdata_out[0] == 1'b0)
		else $error("first status spare bit set");
	a_second_spare_zero: assert property (reg_rd_in && reg_addr_in == 8'h42 |=>
		reg_rdata_out[0] == 1'b0)
		else $error("second status spare bit set");
endmodule

bind ashtmr_top ashtmr_assertions u_chk (
	.clk_in                  (clk_in),
	.rst_n_in                (rst_n_in),
	.reg_addr_in             (reg_addr_in),
	.reg_rd_in               (reg_rd_in),
	.reg_rdata_out           (reg_rdata_out),
	.fans_running_in         (fans_running_in),
	.full_speed_override_out (full_speed_override_out),
	.alert_pin5_n_out        (alert_pin5_n_out),
	.mf_pin_in               (mf_pin_in),
	.mf_pin_out              (mf_pin_out),
	.mf_pin_oe_n_out         (mf_pin_oe_n_out),
	.gpio_level_in           (gpio_level_in),
	.gpio_drive_in           (gpio_drive_in)
);

// File: dv/ashtmr_host.sv
// host model that writes and reads registers on the parallel register port
`timescale 1ns/100ps

module ashtmr_host (
	// clock
	input  wire logic clk_in,
	// register port toward the block
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic       reg_wr_out,
	output logic       reg_rd_out
);
	// idle bus at time zero
	initial begin
		reg_addr_out  = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
	end

	// one write strobe; released fields are inverted so stale values never help
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		reg_addr_out  = a;
		reg_wdata_out = d;
		reg_wr_out    = 1'b1;
		@(negedge clk_in);
		reg_wr_out    = 1'b0;
		reg_addr_out  = ~a;
		reg_wdata_out = ~d;
	endtask

	// one read strobe
	task automatic rd(input logic [7:0] a);
		@(negedge clk_in);
		reg_addr_out = a;
		reg_rd_out   = 1'b1;
		@(negedge clk_in);
		reg_rd_out   = 1'b0;
		reg_addr_out = ~a;
	endtask
endmodule

// File: dv/ashtmr_top_tb.sv
// self-checking bench for the alert status and hot timer block
`timescale 1ns/100ps

module ashtmr_top_tb;
	// ==========================================
	// signals
	logic                        clk_in      = 1'b0;
	logic                        rst_n_in    = 1'b0;
	logic [7:0]                  reg_addr;
	logic [7:0]                  reg_wdata;
	logic                        reg_wr;
	logic                        reg_rd;
	logic [7:0]                  reg_rdata;
	ashtmr_pkg::ashtmr_cond_type cond        = '0;
	logic [2:0]                  fans        = 3'h0;
	logic [2:0]                  fso;
	logic                        alert_n;
	logic                        mf_out;
	logic                        mf_oe_n;
	logic                        ext_n       = 1'b1;  // far driver of the hot pin
	logic                        gpio_lvl    = 1'b0;
	logic                        gpio_drv    = 1'b0;
	logic                        rd_q        = 1'b0;  // a read was taken
	logic [7:0]                  exp_q[$];            // expected read data
	int                          miscompares = 0;
	int                          comparisons = 0;
	int                          cycles      = 0;
	wire                         mf_wire;
	localparam logic [7:0] WA [8] = '{8'h74, 8'h75, 8'h78, 8'h7a, 8'h7d, 8'h79, 8'h42, 8'h10};
	localparam int         SB [5] = '{1, 2, 4, 5, 6};  // first status bits

	// pin level: block drive wins, else the far driver (pulled up)
	assign mf_wire = mf_oe_n ? ext_n : mf_out;

	initial forever #5 clk_in = ~clk_in;

	ashtmr_top #(.HOT_TICK_CYCLES(10)) u_dut (
		.clk_in                  (clk_in),
		.rst_n_in                (rst_n_in),
		.reg_addr_in             (reg_addr),
		.reg_wdata_in            (reg_wdata),
		.reg_wr_in               (reg_wr),
		.reg_rd_in               (reg_rd),
		.reg_rdata_out           (reg_rdata),
		.cond_in                 (cond),
		.fans_running_in         (fans),
		.full_speed_override_out (fso),
		.alert_pin5_n_out        (alert_n),
		.mf_pin_in               (mf_wire),
		.mf_pin_out              (mf_out),
		.mf_pin_oe_n_out         (mf_oe_n),
		.gpio_level_in           (gpio_lvl),
		.gpio_drive_in           (gpio_drv)
	);

	ashtmr_host u_host (
		.clk_in        (clk_in),
		.reg_addr_out  (reg_addr),
		.reg_wdata_out (reg_wdata),
		.reg_wr_out    (reg_wr),
		.reg_rd_out    (reg_rd)
	);

	// ==========================================
	// checking
	task automatic tally(input logic bad, input string what);
		comparisons++;
		if (bad !== 1'b0) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		tally(got !== exp, $sformatf("read %h expected %h", got, exp));
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		tally(got !== exp, $sformatf("pins %h expected %h", got, exp));
	endtask
	// note the expected value, then read
	task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.rd(a);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic end_of_test();
		if (miscompares == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// read data is settled half a cycle after the taking edge
	always @(posedge clk_in) rd_q <= reg_rd;
	always @(negedge clk_in) begin
		if (rd_q && exp_q.size() > 0) begin
			chk_rd(reg_rdata, exp_q.pop_front());
		end
	end

	// hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			end_of_test();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		logic [7:0] v;
		int         b;
		int         mb;
		logic       s2;
		v = 8'($urandom(32'h9c90));
		cyc(20);
		rst_n_in = 1'b1;
		chk_pin({3'h0, fso, alert_n, mf_oe_n}, 8'h03);
		// reset values, read-write, refused and unmapped places
		foreach (WA[i]) rd_exp(WA[i], 8'h00);
		foreach (WA[i]) begin
			v = 8'($urandom);
			u_host.wr(WA[i], v);
			rd_exp(WA[i], (i < 5) ? v : 8'h00);
			u_host.wr(WA[i], 8'h00);
		end
		// every source, unmasked then masked
		u_host.wr(8'h78, 8'h01);
		for (int k = 0; k < 12; k++) begin
			for (int m = 0; m < 2; m++) begin
				s2 = (k < 7);
				b  = s2 ? k + 1 : SB[k - 7];
				mb = (!s2 && b == 1) ? 0 : b;
				u_host.wr(8'h74, !m ? 8'h00 : s2 ? {k[0], 7'h00} : 8'(1 << mb));
				u_host.wr(8'h75, (m && s2 && !k[0]) ? 8'(1 << b) : 8'h00);
				cond[k] = 1'b1;
				cyc(2);
				chk_pin({7'h0, alert_n}, 8'(m));
				cond[k] = 1'b0;
				cyc(2);
				chk_pin({7'h0, alert_n}, 8'(m));
				rd_exp(8'h41, s2 ? 8'h80 : 8'(1 << b));
				rd_exp(8'h42, s2 ? 8'(1 << b) : 8'h00);
				rd_exp(8'h41, 8'h00);
				chk_pin({7'h0, alert_n}, 8'h01);
			end
		end
		u_host.wr(8'h74, 8'h00);
		// a read does not clear a present condition
		cond[1] = 1'b1;
		cyc(2);
		rd_exp(8'h42, 8'h04);
		rd_exp(8'h42, 8'h04);
		cond[1] = 1'b0;
		rd_exp(8'h42, 8'h04);
		rd_exp(8'h42, 8'h00);
		// pin roles: alert, gpio, tach
		u_host.wr(8'h78, 8'h00);
		u_host.wr(8'h7d, 8'h02);
		cond[0] = 1'b1;
		cyc(2);
		chk_pin({6'h0, mf_oe_n, mf_out}, 8'h00);
		chk_pin({7'h0, alert_n}, 8'h01);
		cond[0] = 1'b0;
		rd_exp(8'h42, 8'h02);
		chk_pin({7'h0, mf_oe_n}, 8'h01);
		u_host.wr(8'h7d, 8'h03);
		gpio_lvl = 1'($urandom);
		gpio_drv = 1'b1;
		cyc(2);
		chk_pin({6'h0, mf_oe_n, mf_out}, {7'h0, gpio_lvl});
		gpio_drv = 1'b0;
		u_host.wr(8'h7d, 8'h00);
		cyc(2);
		chk_pin({7'h0, mf_oe_n}, 8'h01);
		// hot role without the enable bit does nothing
		fans = 3'($urandom);
		u_host.wr(8'h7d, 8'h01);
		u_host.wr(8'h78, 8'h05);
		ext_n = 1'b0;
		cyc(30);
		chk_pin({5'h0, fso}, 8'h00);
		ext_n = 1'b1;
		rd_exp(8'h79, 8'h00);
		// timing, override and limit zero
		u_host.wr(8'h78, 8'h07);
		ext_n = 1'b0;
		cyc(35);
		chk_pin({4'h0, fso, alert_n}, {4'h0, fans, 1'b0});
		ext_n = 1'b1;
		cyc(3);
		chk_pin({5'h0, fso}, 8'h00);
		ext_n = 1'b0;
		cyc(10);
		ext_n = 1'b1;
		rd_exp(8'h79, 8'h04);
		rd_exp(8'h79, 8'h00);
		rd_exp(8'h42, 8'h20);
		rd_exp(8'h42, 8'h00);
		// masked timer event, reads during assertion
		u_host.wr(8'h75, 8'h20);
		ext_n = 1'b0;
		cyc(5);
		chk_pin({7'h0, alert_n}, 8'h01);
		rd_exp(8'h79, 8'h01);
		rd_exp(8'h79, 8'h01);
		rd_exp(8'h42, 8'h20);
		ext_n = 1'b1;
		rd_exp(8'h79, 8'h01);
		rd_exp(8'h42, 8'h20);
		rd_exp(8'h42, 8'h00);
		// limit one, then saturation
		u_host.wr(8'h75, 8'h00);
		u_host.wr(8'h7a, 8'h01);
		ext_n = 1'b0;
		cyc(15);
		chk_pin({7'h0, alert_n}, 8'h01);
		cyc(10);
		chk_pin({7'h0, alert_n}, 8'h00);
		cyc(2700);
		ext_n = 1'b1;
		cyc(2);
		rd_exp(8'h79, 8'hff);
		rd_exp(8'h79, 8'h00);
		rd_exp(8'h42, 8'h20);
		// host service: read, mask, poll, unmask
		u_host.wr(8'h7d, 8'h00);
		cond[2] = 1'b1;
		cyc(2);
		chk_pin({7'h0, alert_n}, 8'h00);
		rd_exp(8'h42, 8'h08);
		u_host.wr(8'h75, 8'h08);
		cyc(1);
		chk_pin({7'h0, alert_n}, 8'h01);
		cond[2] = 1'b0;
		rd_exp(8'h42, 8'h08);
		rd_exp(8'h42, 8'h00);
		u_host.wr(8'h75, 8'h00);
		cyc(1);
		chk_pin({7'h0, alert_n}, 8'h01);
		end_of_test();
	end
endmodule
